/* rtl/prs_cfg.svh */
// Offsets, reset values and timing counts of the power-up reset sequencer
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH

// ----------------------------------------
// Register word indices (byte address = index * 4)
// ----------------------------------------
`define PRS_IDX_PWR_CTL 8'h8e
`define PRS_IDX_CFG 8'h90
`define PRS_IDX_STS 8'h91
`define PRS_IDX_MASK 8'h92
`define PRS_IDX_STATE 8'h93

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PRS_PWR_FLAG_BIT 1
`define PRS_CFG_DLY_BIT 3
`define PRS_CFG_MODE_RST 3'h1
`define PRS_CFG_DLY_N_RST 1'b0
`define PRS_EV_POR 0
`define PRS_EV_DELAY 1
`define PRS_EV_START 2
`define PRS_EV_WAKE 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define PRS_CLK_PERIOD_NS 4
`define PRS_RC_PERIOD_NS 1000
`define PRS_POWER_UP_DELAY_TIMER_MS 72
`define PRS_OST_CYCLES 1024
`define PRS_RC_DIV (`PRS_RC_PERIOD_NS / `PRS_CLK_PERIOD_NS)
`define PRS_POWER_UP_DELAY_TIMER_TICKS (`PRS_POWER_UP_DELAY_TIMER_MS * 1000000 / `PRS_RC_PERIOD_NS)

`endif

/* rtl/prs_pkg.sv */
// Types of the power-up reset sequencer
`default_nettype none

package prs_pkg;

	typedef enum logic [2:0] {
		low_power_crystal_mode,
		standard_crystal_mode,
		high_speed_crystal_mode,
		int_rc_mode,
		ext_rc_mode
	} prs_osc_mode_t;

	typedef enum logic [2:0] {
		st_por,
		st_delay,
		st_osc,
		st_run,
		st_wake
	} prs_seq_t;

	typedef struct packed {
		prs_seq_t st;
		logic [31:0] cnt;
		logic osc_prev;
		logic por_flag_n;
		logic [2:0] mode;
		logic dly_dis;
		logic [3:0] sts;
		logic [3:0] mask;
		logic rst_n;
		logic clk_ok;
		logic irq;
		logic aw_have;
		logic [7:0] aw_idx;
		logic aw_hi;
		logic w_have;
		logic [7:0] wdata;
		logic wstb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} prs_regs_t;

endpackage : prs_pkg

`default_nettype wire

/* rtl/prs_rc_tick.sv */
// Stand-in for the dedicated RC oscillator: one-cycle tick enable
`default_nettype none

module prs_rc_tick #(
	parameter int unsigned DIV = 250
) (
	input wire logic clk_sys,
	input wire logic nrst,
	output logic tick
);

	logic [31:0] cnt_q;
	logic [31:0] cnt_d;

	// Runs free from reset, whatever clock mode the chip uses
	always_comb
	begin
		if (cnt_q == 32'(DIV - 1))
			cnt_d = 32'h0;
		else
			cnt_d = cnt_q + 32'h1;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			cnt_q <= 32'h0;
		else
			cnt_q <= cnt_d;
	end

	assign tick = (cnt_q == 32'(DIV - 1));

endmodule : prs_rc_tick

`default_nettype wire

/* rtl/prs_sequencer.sv */
// Power-up reset sequencer with AXI4-Lite register slave
`include "prs_cfg.svh"
`default_nettype none

module prs_sequencer
	import prs_pkg::*;
#(
	parameter int unsigned POWER_UP_DELAY_TIMER_TICKS = `PRS_POWER_UP_DELAY_TIMER_TICKS,
	parameter int unsigned RC_DIV = `PRS_RC_DIV,
	parameter int unsigned OST_CYCLES = `PRS_OST_CYCLES
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic supply_ok,
	input wire logic external_reset_pin_n,
	input wire logic primary_osc_input,
	input wire logic wake_from_sleep,
	output logic chip_reset_n,
	output logic core_clock_ready,
	output logic irq,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	prs_regs_t r_q;
	prs_regs_t r_d;
	logic rc_tick;

	// ----------------------------------------
	// RC time base
	// ----------------------------------------
	// Free-running: the first tick lands anywhere within one RC period
	prs_rc_tick #(
		.DIV(RC_DIV)
	) u_rc_tick (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.tick(rc_tick)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb
	begin
		logic [3:0] ev;
		logic [3:0] sts_clr;
		logic xtal;
		logic osc_edge;
		logic aw_take;
		logic w_take;
		logic ar_take;
		logic [7:0] ar_idx;
		logic ar_hi;
		ev = 4'h0;
		sts_clr = 4'h0;
		xtal = 1'b0;
		osc_edge = 1'b0;
		aw_take = 1'b0;
		w_take = 1'b0;
		ar_take = 1'b0;
		ar_idx = 8'h0;
		ar_hi = 1'b0;
		r_d = r_q;

		// ----------------------------------------
		// Clock mode and oscillator edge
		// ----------------------------------------
		// Codes 5 to 7 are unused and behave as RC modes
		case (r_q.mode)
			3'(low_power_crystal_mode),
			3'(standard_crystal_mode),
			3'(high_speed_crystal_mode):
				xtal = 1'b1;
			default:
				xtal = 1'b0;
		endcase
		osc_edge = primary_osc_input && !r_q.osc_prev;
		r_d.osc_prev = primary_osc_input;

		// ----------------------------------------
		// Time-out sequence
		// ----------------------------------------
		case (r_q.st)
			st_por:
			begin
				r_d.cnt = 32'h0;
				if (supply_ok)
				begin
					ev[`PRS_EV_POR] = 1'b1;
					// Delay enable is active low
					if (!r_q.dly_dis)
						r_d.st = st_delay;
					else if (xtal)
						r_d.st = st_osc;
					else
					begin
						r_d.st = st_run;
						ev[`PRS_EV_START] = 1'b1;
					end
				end
			end
			// One counter serves the delay, oscillator and wake stages and is cleared on every exit
			st_delay:
			begin
				if (rc_tick)
				begin
					if (r_q.cnt == 32'(POWER_UP_DELAY_TIMER_TICKS - 1))
					begin
						r_d.cnt = 32'h0;
						ev[`PRS_EV_DELAY] = 1'b1;
						if (xtal)
							r_d.st = st_osc;
						else
						begin
							r_d.st = st_run;
							ev[`PRS_EV_START] = 1'b1;
						end
					end
					else
						r_d.cnt = r_q.cnt + 32'h1;
				end
			end
			// A dead crystal gives no edges: only supply loss or nrst leaves
			st_osc:
			begin
				if (osc_edge)
				begin
					if (r_q.cnt == 32'(OST_CYCLES - 1))
					begin
						r_d.cnt = 32'h0;
						r_d.st = st_run;
						ev[`PRS_EV_START] = 1'b1;
					end
					else
						r_d.cnt = r_q.cnt + 32'h1;
				end
			end
			st_run:
			begin
				r_d.cnt = 32'h0;
				// Wake-up reruns only the oscillator count, never the delay
				if (wake_from_sleep && xtal)
					r_d.st = st_wake;
			end
			st_wake:
			begin
				if (osc_edge)
				begin
					if (r_q.cnt == 32'(OST_CYCLES - 1))
					begin
						r_d.cnt = 32'h0;
						r_d.st = st_run;
						ev[`PRS_EV_WAKE] = 1'b1;
					end
					else
						r_d.cnt = r_q.cnt + 32'h1;
				end
			end
			default:
			begin
				r_d.st = st_por;
				r_d.cnt = 32'h0;
			end
		endcase

		// Supply loss restarts the time-out sequence, wherever it stood
		if (!supply_ok)
		begin
			r_d.st = st_por;
			r_d.cnt = 32'h0;
			ev = 4'h0;
		end

		// ----------------------------------------
		// Write channel
		// ----------------------------------------
		// Only byte lane 0 is kept; every register is one byte wide
		aw_take = s_axi_awvalid && !r_q.aw_have;
		w_take = s_axi_wvalid && !r_q.w_have;
		if (aw_take)
		begin
			r_d.aw_have = 1'b1;
			r_d.aw_idx = s_axi_awaddr[9:2];
			r_d.aw_hi = |s_axi_awaddr[11:10];
		end
		if (w_take)
		begin
			r_d.w_have = 1'b1;
			r_d.wdata = s_axi_wdata[7:0];
			r_d.wstb = s_axi_wstrb[0];
		end
		if (r_q.bvalid && s_axi_bready)
			r_d.bvalid = 1'b0;
		if (r_q.aw_have && r_q.w_have && !r_q.bvalid)
		begin
			r_d.aw_have = 1'b0;
			r_d.w_have = 1'b0;
			r_d.bvalid = 1'b1;
			r_d.bresp = RESP_OKAY;
			if (r_q.aw_hi)
				r_d.bresp = RESP_SLVERR;
			else if (r_q.aw_idx == `PRS_IDX_PWR_CTL)
			begin
				if (r_q.wstb)
					r_d.por_flag_n = r_q.wdata[`PRS_PWR_FLAG_BIT];
			end
			else if (r_q.aw_idx == `PRS_IDX_CFG)
			begin
				if (r_q.wstb)
				begin
					r_d.mode = r_q.wdata[2:0];
					r_d.dly_dis = r_q.wdata[`PRS_CFG_DLY_BIT];
				end
			end
			else if (r_q.aw_idx == `PRS_IDX_MASK)
			begin
				if (r_q.wstb)
					r_d.mask = r_q.wdata[3:0];
			end
			else if (r_q.aw_idx == `PRS_IDX_STS || r_q.aw_idx == `PRS_IDX_STATE)
				r_d.bresp = RESP_OKAY;
			else
				r_d.bresp = RESP_SLVERR;
		end

		// ----------------------------------------
		// Read channel
		// ----------------------------------------
		if (r_q.rvalid && s_axi_rready)
			r_d.rvalid = 1'b0;
		ar_take = s_axi_arvalid && !r_q.rvalid;
		ar_idx = s_axi_araddr[9:2];
		ar_hi = |s_axi_araddr[11:10];
		if (ar_take)
		begin
			r_d.rvalid = 1'b1;
			r_d.rresp = RESP_OKAY;
			r_d.rdata = 32'h0;
			if (ar_hi)
				r_d.rresp = RESP_SLVERR;
			else if (ar_idx == `PRS_IDX_PWR_CTL)
				r_d.rdata[`PRS_PWR_FLAG_BIT] = r_q.por_flag_n;
			else if (ar_idx == `PRS_IDX_CFG)
				r_d.rdata[3:0] = {r_q.dly_dis, r_q.mode};
			else if (ar_idx == `PRS_IDX_STS)
			begin
				r_d.rdata[3:0] = r_q.sts;
				sts_clr = r_q.sts;
			end
			else if (ar_idx == `PRS_IDX_MASK)
				r_d.rdata[3:0] = r_q.mask;
			else if (ar_idx == `PRS_IDX_STATE)
				r_d.rdata[5:0] = {supply_ok, r_q.clk_ok, r_q.rst_n, r_q.st};
			else
				r_d.rresp = RESP_SLVERR;
		end

		// ----------------------------------------
		// Power flag, status and outputs
		// ----------------------------------------
		// Power-on clear outranks a software write in the same cycle
		if (!supply_ok)
			r_d.por_flag_n = 1'b0;

		// A new event outranks the read-clear that meets it
		r_d.sts = (r_q.sts & ~sts_clr) | ev;
		r_d.irq = |(r_d.sts & r_d.mask);

		// Timers never look at the pin; the pin only gates the release
		r_d.rst_n = supply_ok && external_reset_pin_n
			&& (r_d.st == st_run || r_d.st == st_wake);
		r_d.clk_ok = (r_d.st == st_run);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			r_q <= '0;
			r_q.st <= st_por;
			r_q.mode <= `PRS_CFG_MODE_RST;
			r_q.dly_dis <= `PRS_CFG_DLY_N_RST;
		end
		else
			r_q <= r_d;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign chip_reset_n = r_q.rst_n;
	assign core_clock_ready = r_q.clk_ok;
	assign irq = r_q.irq;
	// Ready comes from flops only, so valid never loops back to ready
	assign s_axi_awready = !r_q.aw_have;
	assign s_axi_wready = !r_q.w_have;
	assign s_axi_bvalid = r_q.bvalid;
	assign s_axi_bresp = r_q.bresp;
	assign s_axi_arready = !r_q.rvalid;
	assign s_axi_rvalid = r_q.rvalid;
	assign s_axi_rdata = r_q.rdata;
	assign s_axi_rresp = r_q.rresp;

endmodule : prs_sequencer

`default_nettype wire

/* verif/prs_properties.sv */
// Port assertions of the power-up reset sequencer
`default_nettype none
module prs_properties (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic supply_ok,
	input wire logic external_reset_pin_n,
	input wire logic chip_reset_n,
	input wire logic core_clock_ready,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_rresp
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	a_por_holds: assert property (!supply_ok |=> !chip_reset_n && !core_clock_ready)
		else $error("reset not held at low supply");
	a_release_clean: assert property ($rose(chip_reset_n) |-> $past(supply_ok) && $past(external_reset_pin_n))
		else $error("reset left with supply or pin low");
	a_pin_holds: assert property (core_clock_ready && !external_reset_pin_n |=> !chip_reset_n)
		else $error("pin low did not hold reset");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
		|-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_slverr_far: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:10] != 2'h0 |=> s_axi_rresp == 2'h2)
		else $error("far address not refused");
	a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not withdrawn");
	c_release: cover property ($rose(chip_reset_n));
	c_pin_hold: cover property (core_clock_ready && !chip_reset_n);
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	a_wake_no_reset: assert property ($fell(core_clock_ready) && $past(supply_ok)
		&& $past(external_reset_pin_n) |-> chip_reset_n)
		else $error("wake count pulled reset");
	c_wake: cover property (chip_reset_n && $fell(core_clock_ready));
endmodule : prs_properties
bind prs_sequencer prs_properties prs_properties_i (.*);
`default_nettype wire

/* verif/prs_osc_model.sv */
// Crystal stand-in on the primary oscillator input
`default_nettype none
module prs_osc_model (
	input wire logic clk_sys,
	input wire logic osc_on,
	input wire logic slow,
	output var logic primary_osc_input
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div_q = 2'h0;
	logic osc_q = 1'b0;
	// Not started: input stands still, as a dead crystal would
	assign primary_osc_input = osc_q;
	always @(posedge clk_sys)
	begin
		div_q <= div_q + 2'h1;
		if (osc_on && (!slow || div_q == 2'h3))
			osc_q <= !osc_q;
	end
endmodule : prs_osc_model
`default_nettype wire

/* verif/test_prs_sequencer.sv */
// Self-checking bench of the power-up reset sequencer
`default_nettype none
module test_prs_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0, nrst = 1'b0, supply_ok = 1'b0, external_reset_pin_n = 1'b1, wake_from_sleep = 1'b0;
	logic osc_on = 1'b0, osc_slow = 1'b0, chip_reset_n, core_clock_ready, irq, primary_osc_input;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, lfsr_q = 32'hcb3e;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [34:0] exp_q[$], mon_e;
	int bad_count = 0, samples_checked = 0, n;

	// Short counts keep the run brief: 20 ticks of 4 clocks, 8 edges
	prs_sequencer #(.POWER_UP_DELAY_TIMER_TICKS(20), .RC_DIV(4), .OST_CYCLES(8)) prs_sequencer_i (.*);
	prs_osc_model prs_osc_model_i (.clk_sys, .osc_on, .slow(osc_slow), .primary_osc_input);

	initial forever #2 clk_sys = ~clk_sys;

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next

	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [34:0] seen, input logic [34:0] exp, input string what);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic edge_until(ref logic s, output int k);
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
			if (k > 3000)
			begin
				bad_count++;
				tally_and_finish();
			end
		end
		while (s !== 1'b1);
	endtask : edge_until

	task automatic axi_write(input logic [11:0] a, input logic [7:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		n = 0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Each channel lets go only at its own handshake
		while (!(aw_done && w_done))
		begin
			@(posedge clk_sys);
			n++;
			if (!aw_done && s_axi_awready === 1'b1)
			begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1)
			begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
			if (n > 3000)
			begin
				bad_count++;
				tally_and_finish();
			end
		end
		edge_until(s_axi_bvalid, n);
		s_axi_bready <= 1'b0;
	endtask : axi_write

	// Top bit of a note: answer only drained, not compared
	task automatic axi_read(input logic [11:0] a, input logic [34:0] e);
		@(posedge clk_sys);
		exp_q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		edge_until(s_axi_arready, n);
		s_axi_arvalid <= 1'b0;
		edge_until(s_axi_rvalid, n);
		s_axi_rready <= 1'b0;
	endtask : axi_read

	task automatic power_up();
		@(posedge clk_sys);
		supply_ok <= 1'b0;
		repeat (3) @(posedge clk_sys);
		supply_ok <= 1'b1;
	endtask : power_up

	always @(posedge clk_sys)
	begin
		if (s_axi_rvalid && s_axi_rready)
		begin
			mon_e = exp_q.pop_front();
			if (!mon_e[34])
				check({1'b0, s_axi_rresp, s_axi_rdata}, mon_e, "read data");
		end
	end

	initial
	begin
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		axi_read(12'h238, 35'h0);
		axi_read(12'h240, 35'h1);
		axi_read(12'h400, 35'h200000000);
		axi_read(12'h244, 35'h0);
		axi_write(12'h248, 8'h1);
		$display("defaults done");
		supply_ok <= 1'b1;
		repeat (10) @(posedge clk_sys);
		axi_read(12'h24c, 35'h21);
		repeat (120) @(posedge clk_sys);
		check(chip_reset_n, 1'b0, "held for oscillator");
		axi_read(12'h24c, 35'h22);
		osc_slow <= 1'b1;
		osc_on <= 1'b1;
		edge_until(chip_reset_n, n);
		check(n > 50 && n < 100, 1'b1, "oscillator count");
		check(irq, 1'b1, "irq raised");
		axi_read(12'h244, 35'h7);
		repeat (3) @(posedge clk_sys);
		check(irq, 1'b0, "irq cleared");
		$display("crystal power-up done");
		axi_write(12'h238, 8'h2);
		external_reset_pin_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		check(chip_reset_n, 1'b0, "pin reset");
		external_reset_pin_n <= 1'b1;
		axi_read(12'h238, 35'h2);
		axi_write(12'h240, 8'h3);
		power_up();
		edge_until(chip_reset_n, n);
		check(n > 75 && n < 90, 1'b1, "delay length");
		axi_read(12'h238, 35'h0);
		$display("delay timing done");
		axi_write(12'h240, 8'hb);
		external_reset_pin_n <= 1'b0;
		power_up();
		repeat (20) @(posedge clk_sys);
		axi_read(12'h24c, 35'h33);
		external_reset_pin_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check(chip_reset_n, 1'b1, "late pin release");
		power_up();
		edge_until(chip_reset_n, n);
		check(n < 4, 1'b1, "no time-out");
		$display("rc mode done");
		axi_write(12'h240, 8'h8);
		power_up();
		edge_until(chip_reset_n, n);
		check(n > 50 && n < 100, 1'b1, "crystal without delay");
		check(core_clock_ready, 1'b1, "clock ready");
		axi_write(12'h240, 8'ha);
		wake_from_sleep <= 1'b1;
		@(posedge clk_sys);
		wake_from_sleep <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check({chip_reset_n, core_clock_ready}, 2'b10, "wake keeps reset off");
		edge_until(core_clock_ready, n);
		check(n > 50 && n < 100, 1'b1, "wake count");
		axi_read(12'h244, 35'hf);
		$display("wake done");
		repeat (4)
		begin
			lfsr_q = lfsr_next(lfsr_q);
			axi_write(12'h248, lfsr_q[7:0]);
			axi_read(12'h248, {31'h0, lfsr_q[3:0]});
		end
		$display("mask done");
		tally_and_finish();
	end
endmodule : test_prs_sequencer
`default_nettype wire
